// ---- rtl/ppr_consts.svh ----
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// Control beat length and reference clock period.
`define PPR_BEAT_NS 2000000
`define PPR_CLK_NS 25
`define PPR_BEAT_MS 2

// Relative scale: 10000 counts equal 100.00 percent.
`define PPR_FULL_PCT 10000
// Proportional gain scale: 1000 counts equal a gain of 100.0.
`define PPR_GAIN_FULL 1000
// Fraction bits of accumulators, filters and the ramp.
`define PPR_FRAC 8
// Integration time counts are 10 ms, so one beat is 1/5 of a count.
`define PPR_TI_BEATS_PER_COUNT 5
// Filter and ramp times count in 10 ms units.
`define PPR_TIME_UNIT_MS 10
// Ramp step numerator: full scale, fraction, beat, over the 10 ms unit.
`define PPR_RAMP_NUM ((`PPR_FULL_PCT << `PPR_FRAC) * `PPR_BEAT_MS / `PPR_TIME_UNIT_MS)

// Setpoint source codes.
`define PPR_SP_STORED 3'h0
`define PPR_SP_AIN1 3'h1
`define PPR_SP_AIN2 3'h2
`define PPR_SP_AIN3 3'h3
`define PPR_SP_PULSE 3'h4
`define PPR_SP_COMM 3'h5
`define PPR_SP_MSTEP 3'h6

// Feedback source codes.
`define PPR_FB_AIN1 4'h0
`define PPR_FB_AIN2 4'h1
`define PPR_FB_AIN3 4'h2
`define PPR_FB_DIFF 4'h3
`define PPR_FB_PULSE 4'h4
`define PPR_FB_COMM 4'h5
`define PPR_FB_SUM 4'h6
`define PPR_FB_MAX 4'h7
`define PPR_FB_MIN 4'h8

// Gain set switch modes.
`define PPR_SW_NEVER 2'h0
`define PPR_SW_TERMINAL 2'h1
`define PPR_SW_AUTO 2'h2

// Setting defaults, for whoever drives the setting ports.
`define PPR_DEF_SETPOINT 16'h1388
`define PPR_DEF_FULL_SCALE 16'h03e8
`define PPR_DEF_PROP_GAIN 16'h00c8
`define PPR_DEF_INT_TIME 16'h00c8
`define PPR_DEF_DER_TIME 16'h0000
`define PPR_DEF_REV_CUTOFF 16'h00c8
`define PPR_DEF_DEAD_BAND 16'h0001
`define PPR_DEF_DER_CLAMP 16'h000a
`define PPR_DEF_SW_LOW 16'h07d0
`define PPR_DEF_SW_HIGH 16'h1f40

`endif

// ---- rtl/ppr_pkg.sv ----
package ppr_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_FILTER, PH_COMPUTE, PH_PUBLISH} ppr_phase_type;

  typedef struct packed {
    logic [1:0] invSync;
    logic [1:0] swSync;
    logic [31:0] tickCnt;
    ppr_phase_type phase;
    logic [15:0] fbPrev;
    logic signed [31:0] integ;
    logic signed [23:0] pidFreq;
    logic signed [23:0] freqCmd;
    logic [15:0] spDisp;
    logic [15:0] fbDisp;
    logic held;
  } ppr_state_type;

  typedef struct packed {
    logic signed [31:0] acc;
  } ppr_lp_state_type;

  typedef struct packed {
    logic [23:0] pos;
  } ppr_ramp_state_type;

endpackage : ppr_pkg

// ---- rtl/ppr_lowpass.sv ----
`timescale 1ns/1ps
`include "ppr_consts.svh"

// First-order low-pass stepped once per beat; a zero time passes the input.
module ppr_lowpass import ppr_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [15:0] tau,
  input wire logic signed [23:0] x,
  output logic signed [23:0] y
);

  ppr_lp_state_type q, d;

  // Step is beat over (time plus beat); tiny errors over long times round to zero.
  always_comb begin
    logic signed [39:0] diff;
    logic signed [39:0] den;
    diff = 40'(x) * 40'sd256 - 40'(q.acc);
    den = 40'(tau) * `PPR_TIME_UNIT_MS + `PPR_BEAT_MS;
    d = q;
    if (step) begin
      if (tau == 16'h0000) begin
        d.acc = 32'(40'(x) * 40'sd256);
      end else begin
        d.acc = q.acc + 32'(diff * `PPR_BEAT_MS / den);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign y = 24'(q.acc >>> `PPR_FRAC);

endmodule : ppr_lowpass

// ---- rtl/ppr_ramp.sv ----
`timescale 1ns/1ps
`include "ppr_consts.svh"

// Linear setpoint ramp; the time is the span of a full-scale move.
module ppr_ramp import ppr_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [15:0] target,
  input wire logic [15:0] rampTime,
  output logic [15:0] value
);

  ppr_ramp_state_type q, d;

  // The move never overshoots the target, so the ramp settles exactly.
  always_comb begin
    logic [23:0] tgt;
    logic [23:0] rate;
    tgt = {target, 8'h00};
    rate = (rampTime == 16'h0000) ? 24'hffffff : 24'(`PPR_RAMP_NUM / rampTime);
    if (rate == 24'h000000) begin
      rate = 24'h000001;
    end
    d = q;
    if (step) begin
      if (rampTime == 16'h0000) begin
        d.pos = tgt;
      end else if (q.pos < tgt) begin
        d.pos = (tgt - q.pos > rate) ? q.pos + rate : tgt;
      end else begin
        d.pos = (q.pos - tgt > rate) ? q.pos - rate : tgt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value = q.pos[23:8];

endmodule : ppr_ramp

// ---- rtl/ppr_process_pid_regulator.sv ----
// Contract
// [RQ1] Setpoint source: 0 stored, 1-3 analog inputs, 4 pulse, 5 comm, 6 multi-step.
// [RQ2] Stored setpoint is 0 to 100 percent relative, default 50 percent.
// [RQ3] Feedback source: analog, difference, pulse, comm, sum, max, min by code 0-8.
// [RQ4] Positive action raises output when feedback is below setpoint.
// [RQ5] Reverse action lowers output when feedback is below setpoint.
// [RQ6] The direction-invert terminal flips the configured action direction.
// [RQ7] Displays scale 100 percent to full-scale number, 0 to 65535, default 1000.
// [RQ8] Gain 100.0 at full deviation gives a maximum-frequency adjustment.
// [RQ9] Full deviation integrates one maximum frequency per integration time.
// [RQ10] Full feedback change per derivative time gives maximum frequency; zero disables.
// [RQ11] Negative output magnitude is capped by the reverse cut-off, itself below maximum.
// [RQ12] Inside the dead band the regulator holds its output unchanged; the code holds the result ahead of the output filter, which keeps settling.
// [RQ13] The derivative contribution is clamped to a configurable range.
// [RQ14] The setpoint ramps linearly; the time spans full scale, zero steps.
// [RQ15] Feedback passes a low-pass filter; zero time bypasses it.
// [RQ16] The frequency output passes a low-pass filter; zero time bypasses it.
// [RQ17] A second gain set exists; switch mode 0 never, 1 terminal, 2 auto.
// [RQ18] In terminal mode the gain-switch terminal selects set two while active.
// [RQ19] Auto mode uses set one low, set two high, interpolating between.
// [RQ20] The output is recomputed once per 2 ms control beat.
// [RQ21] Output is P plus I plus D relative to maximum, bounded by maximum.
// [RQ22] Reset clears integral, filters and ramp; settings default outside.
`timescale 1ns/1ps
`include "ppr_consts.svh"

module ppr_process_pid_regulator import ppr_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `PPR_BEAT_NS / `PPR_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] setpointSourceSelect,
  input wire logic [15:0] storedSetpointValue,
  input wire logic [3:0] feedbackSourceSelect,
  input wire logic actionDirectionSelect,
  input wire logic [15:0] displayFullScale,
  input wire logic [15:0] propGainSetOne,
  input wire logic [15:0] integralTimeSetOne,
  input wire logic [15:0] derivativeTimeSetOne,
  input wire logic [15:0] propGainSetTwo,
  input wire logic [15:0] integralTimeSetTwo,
  input wire logic [15:0] derivativeTimeSetTwo,
  input wire logic [15:0] reverseCutoffFrequency,
  input wire logic [15:0] deviationDeadBand,
  input wire logic [15:0] derivativeClamp,
  input wire logic [15:0] setpointRampTime,
  input wire logic [15:0] feedbackFilterTime,
  input wire logic [15:0] outputFilterTime,
  input wire logic [1:0] gainSetSwitchMode,
  input wire logic [15:0] switchThresholdLow,
  input wire logic [15:0] switchThresholdHigh,
  input wire logic [15:0] maxFrequency,
  input wire logic [15:0] analogInputOne,
  input wire logic [15:0] analogInputTwo,
  input wire logic [15:0] analogInputThree,
  input wire logic [15:0] pulseInputTerminal,
  input wire logic [15:0] commValue,
  input wire logic [15:0] multiStepValue,
  input wire logic directionInvertTerminal,
  input wire logic gainSwitchTerminal,
  output logic signed [23:0] freqCommand,
  output logic [15:0] setpointDisplay,
  output logic [15:0] feedbackDisplay,
  output logic adjustHeld
);

  // The beat needs four cycles for its filter, compute and publish phases.
  if (TICK_CYCLES < 4) begin : g_tick_check
    $error("TICK_CYCLES must be at least 4");
  end

  // Relative value times the display full scale, over 100 percent.
  function automatic logic [15:0] scaleDisplay(input logic [15:0] v, input logic [15:0] fs);
    logic [31:0] p;
    p = 32'(v) * 32'(fs) / `PPR_FULL_PCT;
    return p[15:0];
  endfunction : scaleDisplay

  // Linear blend of two gains by deviation between the two thresholds.
  function automatic logic [15:0] blendGain(input logic [15:0] a, input logic [15:0] b,
                                            input logic [15:0] x, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic signed [39:0] t;
    t = '0;
    if (x <= lo) begin
      t = 40'(a);
    end else if (x >= hi) begin
      t = 40'(b);
    end else begin
      t = $signed(40'(a)) + ($signed(40'(b)) - $signed(40'(a))) * $signed(40'(x - lo)) / $signed(40'(hi - lo));
    end
    return t[15:0];
  endfunction : blendGain

  // Picks one of the two gain sets, or their blend, for one parameter.
  function automatic logic [15:0] pickGain(input logic [1:0] mode, input logic term,
                                           input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] x, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] g;
    g = a;
    unique case (mode)
      `PPR_SW_TERMINAL: g = term ? b : a; // RQ18
      `PPR_SW_AUTO: g = blendGain(a, b, x, lo, hi); // RQ19
      default: g = a;
    endcase
    return g;
  endfunction : pickGain

  ppr_state_type q, d;
  logic [15:0] spTarget;
  logic [15:0] fbSelected;
  logic [15:0] spRamp;
  logic signed [23:0] fbFiltered;
  logic signed [23:0] outFiltered;
  logic filterStep;
  logic computeStep;

  assign filterStep = (q.phase == PH_FILTER);
  assign computeStep = (q.phase == PH_COMPUTE);

  // Setpoint source selection.
  always_comb begin
    unique case (setpointSourceSelect)
      `PPR_SP_STORED: spTarget = storedSetpointValue; // RQ2
      `PPR_SP_AIN1: spTarget = analogInputOne; // RQ1
      `PPR_SP_AIN2: spTarget = analogInputTwo;
      `PPR_SP_AIN3: spTarget = analogInputThree;
      `PPR_SP_PULSE: spTarget = pulseInputTerminal;
      `PPR_SP_COMM: spTarget = commValue;
      `PPR_SP_MSTEP: spTarget = multiStepValue;
      default: spTarget = storedSetpointValue;
    endcase
  end

  // Feedback source selection; difference floors at zero and sum tops at full scale.
  always_comb begin
    logic [16:0] sum;
    sum = 17'(analogInputOne) + 17'(analogInputTwo);
    unique case (feedbackSourceSelect)
      `PPR_FB_AIN1: fbSelected = analogInputOne; // RQ3
      `PPR_FB_AIN2: fbSelected = analogInputTwo;
      `PPR_FB_AIN3: fbSelected = analogInputThree;
      `PPR_FB_DIFF: fbSelected = (analogInputOne > analogInputTwo) ? analogInputOne - analogInputTwo : 16'h0000;
      `PPR_FB_PULSE: fbSelected = pulseInputTerminal;
      `PPR_FB_COMM: fbSelected = commValue;
      `PPR_FB_SUM: fbSelected = (sum > 17'(`PPR_FULL_PCT)) ? 16'(`PPR_FULL_PCT) : sum[15:0];
      `PPR_FB_MAX: fbSelected = (analogInputOne > analogInputTwo) ? analogInputOne : analogInputTwo;
      `PPR_FB_MIN: fbSelected = (analogInputOne < analogInputTwo) ? analogInputOne : analogInputTwo;
      default: fbSelected = analogInputOne;
    endcase
  end

  // Setpoint ramp, stepped once per beat.
  ppr_ramp u_ramp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(filterStep),
    .target(spTarget),
    .rampTime(setpointRampTime),
    .value(spRamp)
  ); // RQ14

  // Feedback filter, stepped once per beat.
  ppr_lowpass u_fb_filter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(filterStep),
    .tau(feedbackFilterTime),
    .x(24'(fbSelected)),
    .y(fbFiltered)
  ); // RQ15

  // Output filter, fed with the fresh regulator result in the compute phase.
  ppr_lowpass u_out_filter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(computeStep),
    .tau(outputFilterTime),
    .x(d.pidFreq),
    .y(outFiltered)
  ); // RQ16

  // Beat sequencer and the regulator arithmetic.
  always_comb begin
    logic [15:0] fb;
    logic signed [39:0] err;
    logic signed [39:0] absErr;
    logic signed [39:0] dFb;
    logic reverse;
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] td;
    logic signed [39:0] pTerm;
    logic signed [39:0] inc;
    logic signed [39:0] integNew;
    logic signed [39:0] dTerm;
    logic signed [39:0] dLim;
    logic signed [39:0] u;
    logic signed [39:0] freq;
    logic signed [39:0] cutoff;
    logic signed [39:0] intLim;
    fb = fbFiltered[15:0];
    err = 40'(spRamp) - 40'(fb);
    absErr = (err < 0) ? -err : err;
    dFb = 40'(fb) - 40'(q.fbPrev);
    reverse = actionDirectionSelect ^ q.invSync[1]; // RQ6
    kp = pickGain(gainSetSwitchMode, q.swSync[1], propGainSetOne, propGainSetTwo,
                  absErr[15:0], switchThresholdLow, switchThresholdHigh); // RQ17
    ti = pickGain(gainSetSwitchMode, q.swSync[1], integralTimeSetOne, integralTimeSetTwo,
                  absErr[15:0], switchThresholdLow, switchThresholdHigh);
    td = pickGain(gainSetSwitchMode, q.swSync[1], derivativeTimeSetOne, derivativeTimeSetTwo,
                  absErr[15:0], switchThresholdLow, switchThresholdHigh);
    if (ti == 16'h0000) begin
      ti = 16'h0001;
    end
    // Reverse action negates the deviation, so a low feedback lowers the output.
    if (reverse) begin
      err = -err; // RQ5
    end else begin
      dFb = -dFb; // RQ4
    end
    pTerm = err * $signed(40'(kp)) / `PPR_GAIN_FULL; // RQ8
    inc = err * 40'sd256 / ($signed(40'(ti)) * `PPR_TI_BEATS_PER_COUNT); // RQ9
    intLim = 40'(`PPR_FULL_PCT) * 40'sd256;
    integNew = 40'(q.integ) + inc;
    // The integral stops at full scale so it cannot wind up without bound.
    if (integNew > intLim) begin
      integNew = intLim;
    end else if (integNew < -intLim) begin
      integNew = -intLim;
    end
    dTerm = dFb * $signed(40'(td)) / `PPR_BEAT_MS; // RQ10
    dLim = 40'(derivativeClamp);
    if (dTerm > dLim) begin
      dTerm = dLim; // RQ13
    end else if (dTerm < -dLim) begin
      dTerm = -dLim;
    end
    u = pTerm + (integNew >>> `PPR_FRAC) + dTerm; // RQ21
    if (u > 40'(`PPR_FULL_PCT)) begin
      u = 40'(`PPR_FULL_PCT);
    end else if (u < -40'(`PPR_FULL_PCT)) begin
      u = -40'(`PPR_FULL_PCT);
    end
    freq = u * $signed(40'(maxFrequency)) / `PPR_FULL_PCT;
    cutoff = (reverseCutoffFrequency > maxFrequency) ? 40'(maxFrequency) : 40'(reverseCutoffFrequency);
    if (freq < -cutoff) begin
      freq = -cutoff; // RQ11
    end

    d = q;
    d.invSync = {q.invSync[0], directionInvertTerminal};
    d.swSync = {q.swSync[0], gainSwitchTerminal};
    d.tickCnt = (q.tickCnt == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : q.tickCnt + 32'h00000001;
    unique case (q.phase)
      PH_IDLE: begin
        if (q.tickCnt == 32'(TICK_CYCLES - 1)) begin
          d.phase = PH_FILTER; // RQ20
        end
      end
      PH_FILTER: begin
        d.phase = PH_COMPUTE;
      end
      PH_COMPUTE: begin
        d.phase = PH_PUBLISH;
        d.fbPrev = fb;
        // Inside the dead band nothing integrates and the last result stands.
        d.held = absErr < 40'(deviationDeadBand); // RQ12
        if (!d.held) begin
          d.integ = 32'(integNew);
          d.pidFreq = 24'(freq);
        end
      end
      PH_PUBLISH: begin
        d.phase = PH_IDLE;
        d.freqCmd = outFiltered;
        d.spDisp = scaleDisplay(spRamp, displayFullScale); // RQ7
        d.fbDisp = scaleDisplay(fb, displayFullScale);
      end
    endcase
  end

  // All regulator state clears on reset, including the integral.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0; // RQ22
    end else begin
      q <= d;
    end
  end

  assign freqCommand = q.freqCmd;
  assign setpointDisplay = q.spDisp;
  assign feedbackDisplay = q.fbDisp;
  assign adjustHeld = q.held;

endmodule : ppr_process_pid_regulator

// ---- verification/ppr_process_pid_regulator_asserts.sv ----
`timescale 1ns/1ps

// Watches the regulator ports; settings are expected to move only mid-beat.
module ppr_process_pid_regulator_asserts #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] setpointSourceSelect,
  input wire logic [3:0] feedbackSourceSelect,
  input wire logic [15:0] storedSetpointValue,
  input wire logic [15:0] displayFullScale,
  input wire logic [15:0] reverseCutoffFrequency,
  input wire logic [15:0] setpointRampTime,
  input wire logic [15:0] feedbackFilterTime,
  input wire logic [15:0] outputFilterTime,
  input wire logic [15:0] maxFrequency,
  input wire logic [15:0] analogInputOne,
  input wire logic signed [23:0] freqCommand,
  input wire logic [15:0] setpointDisplay,
  input wire logic [15:0] feedbackDisplay,
  input wire logic adjustHeld
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] beatPhase_q;
  logic [15:0] capMag;
  logic signed [23:0] capFloor;
  logic [31:0] spExpected;
  logic [31:0] fbExpected;

  // Free-running beat phase, restarted by reset like the design's own counter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || beatPhase_q == TICK_CYCLES - 1) begin
      beatPhase_q <= 32'h0;
    end else begin
      beatPhase_q <= beatPhase_q + 32'h1;
    end
  end

  // The cut-off can never exceed the maximum, so the floor uses the smaller.
  assign capMag = (reverseCutoffFrequency < maxFrequency) ? reverseCutoffFrequency : maxFrequency;
  assign capFloor = -$signed({8'h00, capMag});
  assign spExpected = ({16'h0, storedSetpointValue} * {16'h0, displayFullScale}) / 32'h2710;
  assign fbExpected = ({16'h0, analogInputOne} * {16'h0, displayFullScale}) / 32'h2710;

  property p_reset_clear;
    $rose(rst_n) |-> freqCommand == 24'sh0 && setpointDisplay == 16'h0 && feedbackDisplay == 16'h0 && !adjustHeld;
  endproperty
  property p_beat_phase;
    ($changed(freqCommand) || $changed(setpointDisplay) || $changed(adjustHeld)) |-> beatPhase_q inside {[1:5]};
  endproperty
  property p_hold_beat;
    $changed(freqCommand) |=> $stable(freqCommand) [*7];
  endproperty
  property p_reverse_cap;
    $changed(freqCommand) |-> freqCommand >= capFloor;
  endproperty
  property p_upper_bound;
    $changed(freqCommand) |-> freqCommand <= $signed({8'h00, maxFrequency});
  endproperty
  property p_held_freeze;
    adjustHeld && outputFilterTime == 16'h0 |-> $stable(freqCommand);
  endproperty
  property p_sp_display;
    $changed(setpointDisplay) && setpointSourceSelect == 3'h0 && setpointRampTime == 16'h0
      |-> setpointDisplay == spExpected[15:0];
  endproperty
  property p_fb_display;
    $changed(feedbackDisplay) && feedbackSourceSelect == 4'h0 && feedbackFilterTime == 16'h0
      |-> feedbackDisplay == fbExpected[15:0];
  endproperty

  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  a_beat_phase: assert property (p_beat_phase) else $error("output moved off the beat");
  a_hold_beat: assert property (p_hold_beat) else $error("output changed within a beat");
  a_reverse_cap: assert property (p_reverse_cap) else $error("reverse output beyond cut-off");
  a_upper_bound: assert property (p_upper_bound) else $error("output above maximum");
  a_held_freeze: assert property (p_held_freeze) else $error("output moved while held");
  a_sp_display: assert property (p_sp_display) else $error("setpoint display scaling wrong");
  a_fb_display: assert property (p_fb_display) else $error("feedback display scaling wrong");

  c_held: cover property (adjustHeld);
  c_negative: cover property ($changed(freqCommand) && freqCommand < 24'sh0);
  c_capped: cover property (freqCommand == capFloor);
endmodule : ppr_process_pid_regulator_asserts

// ---- verification/ppr_source_model.sv ----
`timescale 1ns/1ps

// Signal sources ahead of the regulator; each level holds until set again.
module ppr_source_model (
  output logic [15:0] analogInputOne,
  output logic [15:0] analogInputTwo,
  output logic [15:0] analogInputThree,
  output logic [15:0] pulseInputTerminal,
  output logic [15:0] commValue,
  output logic [15:0] multiStepValue
);
  // Called at the falling edge, so the regulator samples settled levels.
  task automatic set_sources(input logic [15:0] a1, a2, a3, pu, co, ms);
    analogInputOne = a1;
    analogInputTwo = a2;
    analogInputThree = a3;
    pulseInputTerminal = pu;
    commValue = co;
    multiStepValue = ms;
  endtask : set_sources
endmodule : ppr_source_model

// ---- verification/ppr_process_pid_regulator_bench.sv ----
`timescale 1ns/1ps
`include "ppr_consts.svh"

module ppr_process_pid_regulator_bench import ppr_pkg::*; ;
  localparam int unsigned TICK = 8;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] setpointSourceSelect;
  logic [3:0] feedbackSourceSelect;
  logic [1:0] gainSetSwitchMode;
  logic actionDirectionSelect, directionInvertTerminal, gainSwitchTerminal;
  logic [15:0] storedSetpointValue, displayFullScale, propGainSetOne, integralTimeSetOne, derivativeTimeSetOne;
  logic [15:0] propGainSetTwo, integralTimeSetTwo, derivativeTimeSetTwo, reverseCutoffFrequency;
  logic [15:0] deviationDeadBand, derivativeClamp, setpointRampTime, feedbackFilterTime, outputFilterTime;
  logic [15:0] switchThresholdLow, switchThresholdHigh, maxFrequency;
  logic [15:0] analogInputOne, analogInputTwo, analogInputThree, pulseInputTerminal, commValue, multiStepValue;
  logic signed [23:0] freqCommand, base;
  logic [15:0] setpointDisplay, feedbackDisplay;
  logic adjustHeld;
  int miscompares = 0;
  int samples_checked = 0;
  // Sources as seen by each select code; feedback fixed at 5.00 percent for setpoints.
  logic [15:0] spTable [7] = '{16'h04b0, 16'h05dc, 16'h03e8, 16'h01f4, 16'h02bc, 16'h0384, 16'h044c};
  logic [15:0] fbTable [9] = '{16'h05dc, 16'h03e8, 16'h01f4, 16'h01f4, 16'h02bc, 16'h0384, 16'h09c4,
                               16'h05dc, 16'h03e8};
  // Gain cases: mode and terminal, thresholds, expected output for a 5.00 percent deviation.
  logic [2:0] gainModes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h5, 3'h5};
  logic [15:0] lowTable [6] = '{16'h07d0, 16'h07d0, 16'h07d0, 16'h07d0, 16'h0064, 16'h0000};
  logic [15:0] highTable [6] = '{16'h1f40, 16'h1f40, 16'h1f40, 16'h1f40, 16'h0190, 16'h03e8};
  logic [15:0] gainExpected [6] = '{16'h01f4, 16'h01f4, 16'h00fa, 16'h01f4, 16'h00fa, 16'h0177};

  always #12.5 ref_clk = ~ref_clk;

  ppr_process_pid_regulator #(.TICK_CYCLES(TICK)) i_ppr_process_pid_regulator (
    .ref_clk, .rst_n, .setpointSourceSelect, .storedSetpointValue, .feedbackSourceSelect,
    .actionDirectionSelect, .displayFullScale, .propGainSetOne, .integralTimeSetOne, .derivativeTimeSetOne,
    .propGainSetTwo, .integralTimeSetTwo, .derivativeTimeSetTwo, .reverseCutoffFrequency, .deviationDeadBand,
    .derivativeClamp, .setpointRampTime, .feedbackFilterTime, .outputFilterTime, .gainSetSwitchMode,
    .switchThresholdLow, .switchThresholdHigh, .maxFrequency, .analogInputOne, .analogInputTwo,
    .analogInputThree, .pulseInputTerminal, .commValue, .multiStepValue, .directionInvertTerminal,
    .gainSwitchTerminal, .freqCommand, .setpointDisplay, .feedbackDisplay, .adjustHeld);

  ppr_source_model i_ppr_source_model (
    .analogInputOne, .analogInputTwo, .analogInputThree, .pulseInputTerminal, .commValue, .multiStepValue);

  task automatic beats(input int n);
    repeat (n * TICK) @(negedge ref_clk);
  endtask : beats

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    samples_checked++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0d expected %0d", $time, $signed(act), $signed(exp));
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // A hang is cut short well past the length of the sequence.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  // Unit gain, negligible integral and full scale of 10000 make outputs read as deviations.
  initial begin
    i_ppr_source_model.set_sources(16'h05dc, 16'h03e8, 16'h01f4, 16'h02bc, 16'h0384, 16'h044c);
    {setpointSourceSelect, feedbackSourceSelect, gainSetSwitchMode} = {3'h0, 4'h2, 2'h0};
    {actionDirectionSelect, directionInvertTerminal, gainSwitchTerminal} = 3'h0;
    {storedSetpointValue, displayFullScale, maxFrequency} = {16'h04b0, 16'h2710, 16'h2710};
    {propGainSetOne, propGainSetTwo} = {16'h03e8, 16'h01f4};
    {integralTimeSetOne, integralTimeSetTwo} = {16'hffff, 16'hffff};
    {derivativeTimeSetOne, derivativeTimeSetTwo} = {`PPR_DEF_DER_TIME, `PPR_DEF_DER_TIME};
    {reverseCutoffFrequency, deviationDeadBand, derivativeClamp} = {16'h2710, 16'h0000, `PPR_DEF_DER_CLAMP};
    {setpointRampTime, feedbackFilterTime, outputFilterTime} = 48'h0;
    {switchThresholdLow, switchThresholdHigh} = {`PPR_DEF_SW_LOW, `PPR_DEF_SW_HIGH};
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    for (int c = 0; c < 7; c++) begin
      setpointSourceSelect = 3'(c);
      beats(2);
      check(32'(setpointDisplay), 32'(spTable[c]));
      check(32'(freqCommand), 32'(spTable[c]) - 32'h01f4);
    end
    {setpointSourceSelect, storedSetpointValue} = {3'h0, 16'h05dc};
    for (int c = 0; c < 9; c++) begin
      feedbackSourceSelect = 4'(c);
      beats(2);
      check(32'(feedbackDisplay), 32'(fbTable[c]));
      check(32'(freqCommand), 32'h05dc - 32'(fbTable[c]));
    end
    // A one percent feedback jump with a long derivative time hits the clamp for one beat.
    {feedbackSourceSelect, derivativeTimeSetOne} = {4'h1, 16'h03e8};
    beats(2);
    i_ppr_source_model.set_sources(16'h05dc, 16'h044c, 16'h01f4, 16'h02bc, 16'h0384, 16'h044c);
    beats(1);
    check(32'(freqCommand), 32'h0186);
    beats(1);
    check(32'(freqCommand), 32'h0190);
    {derivativeTimeSetOne, deviationDeadBand, storedSetpointValue} = {16'h0000, 16'h0258, 16'h0640};
    beats(2);
    check(32'(freqCommand), 32'h0190);
    check(32'(adjustHeld), 32'h1);
    deviationDeadBand = 16'h0000;
    beats(2);
    check(32'(freqCommand), 32'h01f4);
    for (int k = 0; k < 4; k++) begin
      {actionDirectionSelect, directionInvertTerminal} = 2'(k);
      beats(2);
      check(32'(freqCommand), (k == 1 || k == 2) ? 32'hfffffe0c : 32'h01f4);
    end
    {actionDirectionSelect, directionInvertTerminal, reverseCutoffFrequency} = {2'h2, `PPR_DEF_REV_CUTOFF};
    beats(2);
    check(32'(freqCommand), 32'hffffff38);
    actionDirectionSelect = 1'b0;
    for (int g = 0; g < 6; g++) begin
      {gainSetSwitchMode, gainSwitchTerminal} = gainModes[g];
      {switchThresholdLow, switchThresholdHigh} = {lowTable[g], highTable[g]};
      beats(2);
      check(32'(freqCommand), 32'(gainExpected[g]));
    end
    {gainSetSwitchMode, gainSwitchTerminal} = 3'h0;
    // Ten time units per full scale gives 2.00 percent per beat.
    {setpointRampTime, storedSetpointValue} = {16'h000a, 16'h07d0};
    beats(1);
    check(32'(setpointDisplay), 32'h0708);
    beats(1);
    check(32'(setpointDisplay), 32'h07d0);
    displayFullScale = 16'h07d0;
    beats(2);
    check(32'(setpointDisplay), 32'h0190);
    check(32'(feedbackDisplay), 32'h00dc);
    {propGainSetOne, integralTimeSetOne} = {16'h0000, 16'h0001};
    beats(2);
    base = freqCommand;
    beats(1);
    check(32'(freqCommand - base), 32'h00b4);
    {feedbackFilterTime, outputFilterTime} = 32'h00010001;
    beats(1);
    check(32'(freqCommand), 32'h023a);
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    check(32'(freqCommand), 32'h0);
    check(32'(adjustHeld), 32'h0);
    rst_n = 1'b1;
    beats(2);
    check(32'(feedbackDisplay), 32'h0024);
    complete_run();
  end
endmodule : ppr_process_pid_regulator_bench

bind ppr_process_pid_regulator ppr_process_pid_regulator_asserts #(.TICK_CYCLES(TICK_CYCLES))
  i_ppr_process_pid_regulator_asserts (
  .ref_clk, .rst_n, .setpointSourceSelect, .feedbackSourceSelect, .storedSetpointValue, .displayFullScale,
  .reverseCutoffFrequency, .setpointRampTime, .feedbackFilterTime, .outputFilterTime, .maxFrequency,
  .analogInputOne, .freqCommand, .setpointDisplay, .feedbackDisplay, .adjustHeld);
